// >>> rtl/ptm_pkg.sv
/*
 ptm_pkg: constants, types and register map of the path trace monitor.
 assumes a single 20 MHz system clock and byte addressing on the register bus.
*/
package ptm_pkg;

    localparam int STR_MAX   = 64;
    localparam int STR_SHORT = 16;
    localparam int VEC_W     = STR_MAX * 8;
    localparam int IDX_W     = 6;

    // register byte offsets; string windows hold one byte per word
    localparam logic [11:0] OFF_CTRL     = 12'h000;
    localparam logic [11:0] OFF_STATUS   = 12'h004;
    localparam logic [11:0] OFF_IRQ_STAT = 12'h008;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h00c;
    localparam logic [3:0]  WIN_TX       = 4'h1;
    localparam logic [3:0]  WIN_EXP      = 4'h2;
    localparam logic [3:0]  WIN_RX_VIEW  = 4'h3;
    localparam logic [3:0]  WIN_BASE_VIEW = 4'h4;

    // control field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_LEN64    = 2;
    localparam int CTRL_AIS_DIS  = 3;
    localparam int CTRL_DEFAULTS = 4;
    localparam int CTRL_REREAD   = 5;
    localparam int CTRL_TX_PROV  = 6;

    // status field positions
    localparam int STAT_TIM     = 0;
    localparam int STAT_LEARNED = 1;
    localparam int STAT_AIS     = 2;

    // interrupt bit positions
    localparam int IRQ_W       = 3;
    localparam int IRQ_TIM_SET = 0;
    localparam int IRQ_TIM_CLR = 1;
    localparam int IRQ_RX_STR  = 2;

    // reset values
    localparam logic [7:0]       RST_BYTE     = 8'h00;
    localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 3'h0;

    // view refresh period
    localparam longint REFRESH_MS  = 2000;
    localparam longint CLK_HZ      = 20000000;
    localparam longint REFRESH_CYC = (REFRESH_MS * CLK_HZ) / 1000;

    typedef enum logic [1:0] {
        PTM_MODE_OFF,
        PTM_MODE_AUTO,
        PTM_MODE_MANUAL
    } ptm_mode_t;

    typedef struct packed {
        logic       valid;
        logic       sof;
        logic       lo_order;
        logic [7:0] data;
    } ptm_rx_t;

    typedef struct packed {
        logic       sof;
        logic [7:0] data;
    } ptm_tx_t;

endpackage : ptm_pkg

// >>> rtl/ptm_strbuf.sv
/*
 ptm_strbuf: 64-byte trace string store in flip-flops, byte write, whole-string load.
 assumes write, load and clear are never needed in the same cycle with different intent;
 clear wins over load, load wins over byte write.
*/
`timescale 1ns/1ps
module ptm_strbuf (
    input  wire logic                         sys_clk,
    input  wire logic                         resetn,
    input  wire logic                         clr,
    input  wire logic                         we,
    input  wire logic [ptm_pkg::IDX_W-1:0]    widx,
    input  wire logic [7:0]                   wdat,
    input  wire logic                         ld,
    input  wire logic [ptm_pkg::VEC_W-1:0]    ldvec,
    output logic      [ptm_pkg::VEC_W-1:0]    vec
);
    genvar g;
    generate
        for (g = 0; g < ptm_pkg::STR_MAX; g++) begin : g_byte
            logic [7:0] byte_q;
            wire        hit = we && (int'(widx) == g);
            always_ff @(posedge sys_clk) begin
                if (!resetn || clr) begin
                    byte_q <= ptm_pkg::RST_BYTE;
                end else if (ld) begin
                    byte_q <= ldvec[g*8 +: 8];
                end else if (hit) begin
                    byte_q <= wdat;
                end
            end
            assign vec[g*8 +: 8] = byte_q;
        end
    endgenerate
endmodule : ptm_strbuf

// >>> rtl/ptm_top.sv
/*
 ptm_top: per-port path trace unit, J1 transmit, receive capture, compare, alarm, registers.
 assumes J1 bytes arrive from framer logic on sys_clk, one strobe per frame, with a start
 marker on the first byte of each string; registers on Avalon-MM with waitrequest.
*/
// Decided for this implementation: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module ptm_top #(
    parameter longint REFRESH_CYCLES = ptm_pkg::REFRESH_CYC,
    parameter bit     TX_CAPABLE     = 1'b1
) (
    input  wire logic              sys_clk,
    input  wire logic              resetn,
    input  wire logic [11:0]       avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    input  wire ptm_pkg::ptm_rx_t  rx_j1,
    input  wire logic              tx_j1_req,
    output ptm_pkg::ptm_tx_t       tx_j1,
    output logic                   tim_alarm,
    output logic                   ais_insert,
    output logic                   irq
);
    localparam int VW = ptm_pkg::VEC_W;
    localparam int IW = ptm_pkg::IDX_W;

    ptm_pkg::ptm_mode_t           mode_q;
    logic                         len64_q, ais_dis_q, tx_prov_q, learned_q, tim_q;
    logic                         ack_q, rx_sync_q, cmp_pend_q;
    logic [31:0]                  rdata_q, ref_cnt_q;
    logic [IW-1:0]                tx_idx_q, rx_idx_q;
    logic [ptm_pkg::IRQ_W-1:0]    irq_stat_q, irq_mask_q;
    logic [VW-1:0]                tx_vec, exp_vec, cap_vec, learn_vec, rxv_vec, basev_vec;

    // bus decode: one wait cycle, write lands on the acknowledging edge
    wire        req        = avs_read || avs_write;
    wire        wr_en      = avs_write && ack_q;
    wire [3:0]  win        = avs_address[11:8];
    wire [IW-1:0] widx     = avs_address[7:2];
    wire        hit_ctrl   = avs_address == ptm_pkg::OFF_CTRL;
    wire        hit_stat   = avs_address == ptm_pkg::OFF_STATUS;
    wire        hit_istat  = avs_address == ptm_pkg::OFF_IRQ_STAT;
    wire        hit_imask  = avs_address == ptm_pkg::OFF_IRQ_MASK;
    wire        wr_ctrl    = wr_en && hit_ctrl;
    wire        wr_tx      = wr_en && win == ptm_pkg::WIN_TX && TX_CAPABLE;
    wire        wr_exp     = wr_en && win == ptm_pkg::WIN_EXP;
    wire        dflt       = wr_ctrl && avs_writedata[ptm_pkg::CTRL_DEFAULTS];
    wire        reread     = wr_ctrl && avs_writedata[ptm_pkg::CTRL_REREAD];
    wire [1:0]  wmode      = avs_writedata[ptm_pkg::CTRL_MODE_LSB +: 2];
    wire        monitoring = mode_q != ptm_pkg::PTM_MODE_OFF;
    wire [IW-1:0] len_last = len64_q ? IW'(ptm_pkg::STR_MAX - 1) : IW'(ptm_pkg::STR_SHORT - 1);

    // receive path; only high-order J1 bytes are taken
    wire        rx_take   = rx_j1.valid && !rx_j1.lo_order;
    wire [IW-1:0] rx_widx = rx_j1.sof ? '0 : rx_idx_q;
    wire        rx_we     = rx_take && (rx_j1.sof || rx_sync_q);
    wire        rx_done   = rx_we && rx_widx == len_last;
    wire        manual    = mode_q == ptm_pkg::PTM_MODE_MANUAL;
    wire        auto_m    = mode_q == ptm_pkg::PTM_MODE_AUTO;
    wire [VW-1:0] base_vec = manual ? exp_vec : learn_vec;
    wire [VW-1:0] len_mask = len64_q ? {VW{1'b1}} : {{(VW-128){1'b0}}, {128{1'b1}}};
    wire        mism      = |((cap_vec ^ base_vec) & len_mask);
    wire        learn_now = cmp_pend_q && auto_m && !learned_q;
    wire        ref_tick  = ref_cnt_q >= 32'(REFRESH_CYCLES - 1);
    wire        refresh   = (ref_tick || reread) && monitoring;
    wire        tim_d     = !monitoring ? 1'b0
                          : (cmp_pend_q && !learn_now) ? mism : tim_q;
    wire [ptm_pkg::IRQ_W-1:0] irq_ev = {cmp_pend_q, tim_q && !tim_d, !tim_q && tim_d};
    wire [7:0]  tx_byte   = tx_vec[{tx_idx_q, 3'b000} +: 8];

    ptm_strbuf u_tx (
        .sys_clk (sys_clk), .resetn (resetn), .clr (dflt),
        .we (wr_tx), .widx (widx), .wdat (avs_writedata[7:0]),
        .ld (1'b0), .ldvec ('0), .vec (tx_vec)
    );
    ptm_strbuf u_exp (
        .sys_clk (sys_clk), .resetn (resetn), .clr (dflt),
        .we (wr_exp), .widx (widx), .wdat (avs_writedata[7:0]),
        .ld (1'b0), .ldvec ('0), .vec (exp_vec)
    );
    ptm_strbuf u_cap (
        .sys_clk (sys_clk), .resetn (resetn), .clr (1'b0),
        .we (rx_we), .widx (rx_widx), .wdat (rx_j1.data),
        .ld (1'b0), .ldvec ('0), .vec (cap_vec)
    );
    ptm_strbuf u_learn (
        .sys_clk (sys_clk), .resetn (resetn), .clr (dflt),
        .we (1'b0), .widx ('0), .wdat (8'h00),
        .ld (learn_now), .ldvec (cap_vec), .vec (learn_vec)
    );
    ptm_strbuf u_rxv (
        .sys_clk (sys_clk), .resetn (resetn), .clr (1'b0),
        .we (1'b0), .widx ('0), .wdat (8'h00),
        .ld (refresh), .ldvec (cap_vec), .vec (rxv_vec)
    );
    ptm_strbuf u_basev (
        .sys_clk (sys_clk), .resetn (resetn), .clr (1'b0),
        .we (1'b0), .widx ('0), .wdat (8'h00),
        .ld (refresh), .ldvec (base_vec), .vec (basev_vec)
    );

    // read mux, sampled in the wait cycle so data stands on the acknowledging edge
    wire [31:0] rd_ctrl = {25'h0, tx_prov_q, 2'b00, ais_dis_q, len64_q, mode_q};
    wire [31:0] rd_stat = {29'h0, ais_insert, learned_q, tim_q};
    wire [31:0] rd_mux  =
        hit_ctrl  ? rd_ctrl :
        hit_stat  ? rd_stat :
        hit_istat ? {29'h0, irq_stat_q} :
        hit_imask ? {29'h0, irq_mask_q} :
        win == ptm_pkg::WIN_TX        ? {24'h0, tx_vec[{widx, 3'b000} +: 8]} :
        win == ptm_pkg::WIN_EXP       ? {24'h0, exp_vec[{widx, 3'b000} +: 8]} :
        win == ptm_pkg::WIN_RX_VIEW   ? {24'h0, rxv_vec[{widx, 3'b000} +: 8]} :
        win == ptm_pkg::WIN_BASE_VIEW ? {24'h0, basev_vec[{widx, 3'b000} +: 8]} :
        32'h0000_0000;

    assign avs_waitrequest = req && !ack_q;
    assign avs_readdata    = rdata_q;
    assign tim_alarm       = tim_q;
    assign ais_insert      = tim_q && !ais_dis_q;
    assign irq             = |(irq_stat_q & irq_mask_q);

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q   <= req && !ack_q;
            rdata_q <= (avs_read && !ack_q) ? rd_mux : rdata_q;
        end
    end

    // control register; an illegal mode code leaves the mode unchanged
    always_ff @(posedge sys_clk) begin
        if (!resetn || dflt) begin
            mode_q    <= ptm_pkg::PTM_MODE_OFF;
            len64_q   <= 1'b0;
            ais_dis_q <= 1'b0;
        end else if (wr_ctrl) begin
            mode_q    <= (wmode == 2'h3) ? mode_q : ptm_pkg::ptm_mode_t'(wmode);
            len64_q   <= avs_writedata[ptm_pkg::CTRL_LEN64];
            ais_dis_q <= avs_writedata[ptm_pkg::CTRL_AIS_DIS];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn || dflt) begin
            tx_prov_q <= 1'b0;
        end else if (wr_tx) begin
            tx_prov_q <= 1'b1;
        end
    end

    // transmit: wrap at the configured length; nothing provisioned sends nulls
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            tx_idx_q <= '0;
            tx_j1    <= '0;
        end else if (tx_j1_req) begin
            tx_idx_q   <= (tx_idx_q >= len_last) ? '0 : tx_idx_q + 1'b1;
            tx_j1.sof  <= tx_idx_q == '0;
            tx_j1.data <= (TX_CAPABLE && tx_prov_q) ? tx_byte : ptm_pkg::RST_BYTE;
        end
    end

    // receive alignment; a new start marker or a length change discards a partial string
    always_ff @(posedge sys_clk) begin
        if (!resetn || (wr_ctrl && avs_writedata[ptm_pkg::CTRL_LEN64] != len64_q)) begin
            rx_idx_q   <= '0;
            rx_sync_q  <= 1'b0;
            cmp_pend_q <= 1'b0;
        end else begin
            cmp_pend_q <= rx_done;
            if (rx_we) begin
                rx_idx_q  <= rx_done ? '0 : rx_widx + 1'b1;
                rx_sync_q <= !rx_done;
            end
        end
    end

    // baseline learning restarts whenever the mode is rewritten
    always_ff @(posedge sys_clk) begin
        if (!resetn || dflt || wr_ctrl) begin
            learned_q <= 1'b0;
            tim_q     <= 1'b0;
        end else begin
            learned_q <= learned_q || learn_now;
            tim_q     <= tim_d;
        end
    end

    // refresh timer; counting stops in off mode so views hold still
    always_ff @(posedge sys_clk) begin
        if (!resetn || !monitoring || refresh) begin
            ref_cnt_q <= 32'h0000_0000;
        end else begin
            ref_cnt_q <= ref_cnt_q + 32'h0000_0001;
        end
    end

    // sticky events: a new event beats a same-cycle write-one-to-clear
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            irq_stat_q <= '0;
            irq_mask_q <= ptm_pkg::RST_IRQ_MASK;
        end else begin
            irq_stat_q <= irq_ev | (irq_stat_q &
                          ~((wr_en && hit_istat) ? avs_writedata[2:0] : 3'h0));
            if (wr_en && hit_imask) begin
                irq_mask_q <= avs_writedata[2:0];
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    property p_tx_wrap;
        tx_j1_req && tx_idx_q == len_last |=> tx_idx_q == '0 && !$past(tx_j1.sof);
    endproperty
    a_tx_wrap: assert property (p_tx_wrap) else $error("tx index did not wrap");

    property p_tx_short;
        !len64_q && tx_j1_req && !wr_ctrl |=> tx_idx_q < IW'(ptm_pkg::STR_SHORT);
    endproperty
    a_tx_short: assert property (p_tx_short) else $error("short string overran");

    property p_tx_null;
        tx_j1_req && !tx_prov_q |=> tx_j1.data == 8'h00;
    endproperty
    a_tx_null: assert property (p_tx_null) else $error("null trace not sent");

    property p_rx_only;
        tx_j1_req && !TX_CAPABLE |=> tx_j1.data == 8'h00;
    endproperty
    a_rx_only: assert property (p_rx_only) else $error("receive-only port sent trace");

    property p_manual_alarm;
        cmp_pend_q && manual && mism && !wr_ctrl && !dflt |=> tim_alarm ##1 1'b1;
    endproperty
    a_manual_alarm: assert property (p_manual_alarm) else $error("manual mismatch missed");

    property p_auto_learn;
        learn_now && !wr_ctrl |=> learned_q && !tim_alarm && learn_vec == $past(cap_vec);
    endproperty
    a_auto_learn: assert property (p_auto_learn) else $error("baseline not learned");

    property p_match_clears;
        cmp_pend_q && monitoring && !mism && !wr_ctrl |=> !tim_alarm;
    endproperty
    a_match_clears: assert property (p_match_clears) else $error("alarm held on match");

    property p_ais_block;
        tim_alarm |-> ais_insert != ais_dis_q;
    endproperty
    a_ais_block: assert property (p_ais_block) else $error("ais not suppressed");

    property p_defaults;
        dflt |=> mode_q == ptm_pkg::PTM_MODE_OFF && !tx_prov_q && tx_vec == '0 && exp_vec == '0;
    endproperty
    a_defaults: assert property (p_defaults) else $error("defaults not restored");

    property p_off_hold;
        !monitoring |=> $stable(rxv_vec) && $stable(basev_vec);
    endproperty
    a_off_hold: assert property (p_off_hold) else $error("view changed in off mode");

    property p_reread;
        reread && monitoring |=> rxv_vec == $past(cap_vec);
    endproperty
    a_reread: assert property (p_reread) else $error("reread did not fetch");

    property p_lo_ignored;
        rx_j1.valid && rx_j1.lo_order |=> $stable(cap_vec);
    endproperty
    a_lo_ignored: assert property (p_lo_ignored) else $error("low-order J1 captured");

    property p_tim_off;
        !monitoring |=> !tim_alarm;
    endproperty
    a_tim_off: assert property (p_tim_off) else $error("alarm in off mode");

endmodule : ptm_top

// >>> tb/ptm_peer.sv
/*
 ptm_peer: far-end path terminating port, sends J1 strings and pulls J1 transmit slots.
 assumes the bench calls its tasks just after a rising edge of sys_clk.
*/
`timescale 1ns/1ps
module ptm_peer (
    input  wire logic       sys_clk,
    output ptm_pkg::ptm_rx_t rx_j1,
    output logic            tx_j1_req,
    input  wire ptm_pkg::ptm_tx_t tx_j1
);
    logic [7:0] last_q;

    initial begin
        rx_j1     = '0;
        tx_j1_req = 1'b0;
        last_q    = 8'h00;
    end

    // idle data shows the inverse of the last byte so a stale value never looks valid
    task automatic send(input logic [7:0] s [64], input int len, input logic lo);
        for (int i = 0; i < len; i++) begin
            rx_j1  <= '{valid: 1'b1, sof: 1'(i == 0), lo_order: lo, data: s[i]};
            last_q  = s[i];
            @(posedge sys_clk);
        end
        rx_j1 <= '{valid: 1'b0, sof: 1'b0, lo_order: 1'b0, data: ~last_q};
    endtask : send

    task automatic slot(output ptm_pkg::ptm_tx_t v);
        tx_j1_req <= 1'b1;
        @(posedge sys_clk);
        tx_j1_req <= 1'b0;
        @(posedge sys_clk);
        v = tx_j1;
    endtask : slot
endmodule : ptm_peer

// >>> tb/tb.sv
/*
 tb: register, transmit, compare and alarm tests of the path trace unit.
 assumes ptm_pkg, ptm_top and ptm_peer are compiled first; short refresh period.
*/
`timescale 1ns/1ps
module tb;
    logic              sys_clk       = 1'b0;
    logic              resetn        = 1'b0;
    logic [11:0]       avs_address   = 12'h000;
    logic              avs_read      = 1'b0;
    logic              avs_write     = 1'b0;
    logic [31:0]       avs_writedata = 32'h0;
    logic [31:0]       avs_readdata;
    logic              avs_waitrequest;
    ptm_pkg::ptm_rx_t  rx_j1;
    logic              tx_j1_req;
    ptm_pkg::ptm_tx_t  tx_j1;
    ptm_pkg::ptm_tx_t  ro_tx;
    ptm_pkg::ptm_tx_t  t;
    logic              tim_alarm;
    logic              ais_insert;
    logic              irq;
    logic [31:0]       rd;
    logic [7:0]        sa [64];
    logic [7:0]        sb [64];
    int                err_total = 0;
    int                checked   = 0;

    always #25 sys_clk = ~sys_clk;

    ptm_top #(.REFRESH_CYCLES(50)) DUT (.sys_clk(sys_clk), .resetn(resetn),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rx_j1(rx_j1), .tx_j1_req(tx_j1_req),
        .tx_j1(tx_j1), .tim_alarm(tim_alarm), .ais_insert(ais_insert), .irq(irq));
    // receive-only variant shares every input; only its transmit output is watched
    ptm_top #(.REFRESH_CYCLES(50), .TX_CAPABLE(1'b0)) DUT_RO (.sys_clk(sys_clk),
        .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(),
        .avs_waitrequest(), .rx_j1(rx_j1), .tx_j1_req(tx_j1_req), .tx_j1(ro_tx),
        .tim_alarm(), .ais_insert(), .irq());
    ptm_peer peer (.sys_clk(sys_clk), .rx_j1(rx_j1), .tx_j1_req(tx_j1_req), .tx_j1(tx_j1));

    function automatic logic [11:0] wa(input logic [3:0] w, input int i);
        return {w, i[5:0], 2'b00};
    endfunction : wa

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    // no wait limit of its own: a stuck slave is ended by the watchdog
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= ~w;
        avs_write     <= w;
        do
            @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask : acc

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask : wr

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0);
        cmp(rd, exp);
    endtask : rdc

    task automatic txchk(input int n, input int len, input logic prov);
        for (int i = 0; i < n; i++) begin
            peer.slot(t);
            cmp({23'h0, t}, {23'h0, 1'(i % len == 0), prov ? sa[i % len] : 8'h00});
            cmp({24'h0, ro_tx.data}, 32'h0);
        end
    endtask : txchk

    // tim settles one edge after the edge that takes the last byte, so three edges leave margin
    task automatic rx(input logic [7:0] s [64], input logic lo, input logic [2:0] exp);
        peer.send(s, 16, lo);
        repeat (3) @(posedge sys_clk);
        cmp({29'h0, irq, ais_insert, tim_alarm}, {29'h0, exp});
    endtask : rx

    task automatic results;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results

    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        results();
    end

    initial begin
        for (int i = 0; i < 64; i++) begin
            sa[i] = 8'h30 + 8'(i);
            sb[i] = sa[i];
        end
        sb[15] = 8'h7e;
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        rdc(ptm_pkg::OFF_CTRL, 32'h0);
        rdc(ptm_pkg::OFF_IRQ_MASK, 32'h0);
        rdc(12'hffc, 32'h0);
        txchk(16, 16, 1'b0);
        $display("test reset done");
        for (int i = 0; i < 64; i++) begin
            wr(wa(ptm_pkg::WIN_TX, i), {24'h0, sa[i]});
            wr(wa(ptm_pkg::WIN_EXP, i), {24'h0, sa[i]});
        end
        txchk(32, 16, 1'b1);
        wr(ptm_pkg::OFF_CTRL, 32'h4);
        txchk(65, 64, 1'b1);
        $display("test transmit done");
        wr(ptm_pkg::OFF_IRQ_MASK, 32'h1);
        wr(ptm_pkg::OFF_CTRL, 32'h2);
        rx(sa, 1'b0, 3'b000);
        rx(sb, 1'b0, 3'b111);
        rdc(ptm_pkg::OFF_IRQ_STAT, 32'h5);
        wr(ptm_pkg::OFF_IRQ_STAT, 32'h7);
        cmp({31'h0, irq}, 32'h0);
        wr(ptm_pkg::OFF_CTRL, 32'ha);
        rx(sb, 1'b0, 3'b101);
        rx(sa, 1'b1, 3'b101);
        rx(sa, 1'b0, 3'b100);
        wr(ptm_pkg::OFF_CTRL, 32'h2a);
        repeat (60) @(posedge sys_clk);
        rdc(wa(ptm_pkg::WIN_RX_VIEW, 15), {24'h0, sa[15]});
        rdc(wa(ptm_pkg::WIN_BASE_VIEW, 3), {24'h0, sa[3]});
        $display("test manual done");
        wr(ptm_pkg::OFF_IRQ_STAT, 32'h7);
        wr(ptm_pkg::OFF_CTRL, 32'h1);
        rx(sb, 1'b0, 3'b000);
        rdc(ptm_pkg::OFF_STATUS, 32'h2);
        rx(sa, 1'b0, 3'b111);
        rx(sb, 1'b0, 3'b100);
        repeat (60) @(posedge sys_clk);
        rdc(wa(ptm_pkg::WIN_BASE_VIEW, 15), 32'h7e);
        $display("test auto done");
        wr(ptm_pkg::OFF_CTRL, 32'h10);
        rdc(ptm_pkg::OFF_CTRL, 32'h0);
        rdc(wa(ptm_pkg::WIN_EXP, 0), 32'h0);
        rdc(wa(ptm_pkg::WIN_TX, 0), 32'h0);
        wr(ptm_pkg::OFF_CTRL, 32'h3);
        rdc(ptm_pkg::OFF_CTRL, 32'h0);
        peer.slot(t);
        cmp({24'h0, t.data}, 32'h0);
        wr(ptm_pkg::OFF_IRQ_STAT, 32'h7);
        rx(sa, 1'b0, 3'b000);
        repeat (60) @(posedge sys_clk);
        wr(ptm_pkg::OFF_CTRL, 32'h20);
        rdc(wa(ptm_pkg::WIN_RX_VIEW, 15), 32'h7e);
        $display("test defaults done");
        results();
    end
endmodule : tb
